//--- design/adc0_pkg.sv
// What this block does
// - Codes 0..11 route analog inputs 0..11
// - Codes 12..28 connect no input
// - Code 29 routes the temperature indicator
// - Code 30 routes fixed reference buffer one
// - Writing go starts; reads one while busy
// - Hardware clears go when conversion finishes
// - Enable bit powers converter; clear draws nothing
// - Bit seven ignores writes, reads zero
// - All implemented control bits reset to zero
// - Completion clears go, sets flag, loads result
// - Early clear aborts; fill with last bit
// - Trigger sets go and clears timer counter
package adc0_pkg;

	// ==========================================
	// Register map
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_STAT = 3'h1;
	localparam logic [2:0] ADDR_MASK = 3'h2;
	localparam logic [2:0] ADDR_RESH = 3'h3;
	localparam logic [2:0] ADDR_RESL = 3'h4;

	// ==========================================
	// Field layout and reset values
	typedef struct packed {
		logic unused;
		logic [4:0] chan;
		logic go;
		logic enable;
	} ctrl_s;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [1:0] STAT_RESET = 2'h0;
	localparam int STAT_DONE = 0;
	localparam int STAT_ABORT = 1;

	// ==========================================
	// Channel codes
	localparam logic [4:0] CHAN_LAST_INPUT = 5'h0b;
	localparam logic [4:0] CHAN_TEMP = 5'h1d;
	localparam logic [4:0] CHAN_FIXED_REFERENCE = 5'h1e;

	typedef struct packed {
		logic input_sel;
		logic [3:0] input_index;
		logic temp_sel;
		logic fixed_reference_sel;
	} route_s;

	// Code zero is the reset channel, so its input is selected from reset
	localparam route_s ROUTE_RESET = '{input_sel: 1'b1, input_index: 4'h0, temp_sel: 1'b0,
		fixed_reference_sel: 1'b0};

	// ==========================================
	// Conversion timing
	localparam int RES_BITS = 10;
	localparam int CLK_NS = 8;
	localparam int SETTLE_NS = 40;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

endpackage

//--- design/adc_control_zero.sv
`timescale 1ns/1ps
module adc_control_zero #(
	parameter int RES_BITS = adc0_pkg::RES_BITS
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_trigger,
	output logic o_timer_clear,
	input wire logic i_cmp_above,
	output logic [RES_BITS-1:0] o_dac_code,
	output logic o_power_on,
	output adc0_pkg::route_s o_route,
	output logic o_irq
);

	typedef enum logic [0:0] {st_idle, st_convert} conv_e;

	// ==========================================
	// State
	adc0_pkg::ctrl_s ctrl;
	adc0_pkg::ctrl_s next_ctrl;
	conv_e state;
	conv_e next_state;
	logic [3:0] bit_idx;
	logic [3:0] next_bit_idx;
	logic [2:0] cyc;
	logic [2:0] next_cyc;
	logic [RES_BITS-1:0] sar;
	logic [RES_BITS-1:0] next_sar;
	logic [RES_BITS-1:0] result;
	logic [RES_BITS-1:0] next_result;
	adc0_pkg::route_s next_route;
	logic next_timer_clear;
	logic cmp_meta;
	logic cmp_sync;
	logic [1:0] status;
	logic [1:0] next_status;
	logic [1:0] mask;
	logic [1:0] next_mask;
	logic [7:0] next_rdata;

	adc0_pkg::ctrl_s wctrl;
	logic wr_ctrl;
	logic complete;
	logic aborted;
	logic abort_last;
	logic stat_clear;

	assign wctrl = adc0_pkg::ctrl_s'(i_wdata);
	assign wr_ctrl = i_wr && (i_addr == adc0_pkg::ADDR_CTRL);
	assign o_dac_code = sar;
	assign o_irq = |(status & mask);

	// ==========================================
	// Control register and conversion sequencer
	always_comb begin
		next_ctrl = ctrl;
		next_state = state;
		next_bit_idx = bit_idx;
		next_cyc = cyc;
		next_sar = sar;
		next_result = result;
		next_route = '0;
		next_timer_clear = i_trigger;
		complete = 1'b0;
		aborted = 1'b0;
		abort_last = 1'b0;

		if (wr_ctrl) begin
			next_ctrl.enable = wctrl.enable;
			next_ctrl.chan = wctrl.chan;
		end

		// Last resolved bit sits just above the bit under trial
		for (int i = 1; i < RES_BITS; i++) begin
			if (i == int'(bit_idx) + 1) begin
				abort_last = sar[i];
			end
		end

		case (state)
			st_idle: begin
				// Enable must already be set; a combined write does not start
				if ((wr_ctrl && wctrl.go) || i_trigger) begin
					if (ctrl.enable && next_ctrl.enable) begin
						next_ctrl.go = 1'b1;
						next_state = st_convert;
						next_bit_idx = 4'(RES_BITS - 1);
						next_cyc = 3'h0;
						next_sar = '0;
						next_sar[RES_BITS-1] = 1'b1;
					end
				end
			end
			st_convert: begin
				if (!next_ctrl.enable) begin
					// Power removed: no valid sample to keep
					next_ctrl.go = 1'b0;
					next_state = st_idle;
					next_sar = '0;
				end else if (cyc == 3'(adc0_pkg::SETTLE_CYC - 1) && bit_idx == 4'h0) begin
					// Completion outranks a same-cycle abort write
					next_sar[0] = cmp_sync;
					next_cyc = 3'h0;
					complete = 1'b1;
					next_result = next_sar;
					next_ctrl.go = 1'b0;
					next_state = st_idle;
				end else if (wr_ctrl && !wctrl.go) begin
					// Honoured in resolve cycles too, except the final one, where completion wins
					aborted = 1'b1;
					next_ctrl.go = 1'b0;
					next_state = st_idle;
					for (int i = 0; i < RES_BITS; i++) begin
						if (i <= int'(bit_idx)) begin
							next_result[i] = abort_last;
						end else begin
							next_result[i] = sar[i];
						end
					end
				end else if (cyc == 3'(adc0_pkg::SETTLE_CYC - 1)) begin
					next_sar[bit_idx] = cmp_sync;
					next_cyc = 3'h0;
					next_bit_idx = bit_idx - 4'h1;
					next_sar[bit_idx - 4'h1] = 1'b1;
				end else begin
					next_cyc = cyc + 3'h1;
				end
			end
			default: begin
				next_state = st_idle;
				next_ctrl.go = 1'b0;
			end
		endcase

		next_ctrl.unused = 1'b0;

		if (next_ctrl.chan <= adc0_pkg::CHAN_LAST_INPUT) begin
			next_route.input_sel = 1'b1;
			next_route.input_index = next_ctrl.chan[3:0];
		end else if (next_ctrl.chan == adc0_pkg::CHAN_TEMP) begin
			next_route.temp_sel = 1'b1;
		end else if (next_ctrl.chan == adc0_pkg::CHAN_FIXED_REFERENCE) begin
			next_route.fixed_reference_sel = 1'b1;
		end
		// Reserved and unlisted codes leave every selection off
	end

	always_ff @(posedge i_mclk) begin
		cmp_meta <= i_cmp_above;
		cmp_sync <= cmp_meta;
		if (!i_resetn) begin
			ctrl <= adc0_pkg::ctrl_s'(adc0_pkg::CTRL_RESET);
			state <= st_idle;
			bit_idx <= 4'h0;
			cyc <= 3'h0;
			sar <= '0;
			result <= '0;
			o_route <= adc0_pkg::ROUTE_RESET;
			o_timer_clear <= 1'b0;
			o_power_on <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			state <= next_state;
			bit_idx <= next_bit_idx;
			cyc <= next_cyc;
			sar <= next_sar;
			result <= next_result;
			o_route <= next_route;
			o_timer_clear <= next_timer_clear;
			o_power_on <= next_ctrl.enable;
		end
	end

	// ==========================================
	// Status, mask and read-back
	always_comb begin
		stat_clear = i_rd && (i_addr == adc0_pkg::ADDR_STAT);
		next_status = status;
		next_mask = mask;
		next_rdata = 8'h00;
		if (stat_clear) begin
			next_status = 2'h0;
		end
		// A new event wins over the read that clears
		if (complete) begin
			next_status[adc0_pkg::STAT_DONE] = 1'b1;
		end
		if (aborted) begin
			next_status[adc0_pkg::STAT_ABORT] = 1'b1;
		end
		if (i_wr && (i_addr == adc0_pkg::ADDR_MASK)) begin
			next_mask = i_wdata[1:0];
		end
		if (i_rd) begin
			case (i_addr)
				adc0_pkg::ADDR_CTRL: next_rdata = ctrl;
				adc0_pkg::ADDR_STAT: next_rdata = {6'h00, status};
				adc0_pkg::ADDR_MASK: next_rdata = {6'h00, mask};
				adc0_pkg::ADDR_RESH: next_rdata = result[RES_BITS-1 -: 8];
				adc0_pkg::ADDR_RESL: next_rdata = {result[1:0], 6'h00};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			status <= adc0_pkg::STAT_RESET;
			mask <= 2'h0;
			o_rdata <= 8'h00;
		end else begin
			status <= next_status;
			mask <= next_mask;
			o_rdata <= next_rdata;
		end
	end

	// ==========================================
	// Assertions
	a_reset_clears_ctrl: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		$rose(i_resetn) |-> (ctrl == adc0_pkg::ctrl_s'(adc0_pkg::CTRL_RESET)))
		else $error("control not zero after reset");

	a_unused_reads_zero: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(i_rd && i_addr == adc0_pkg::ADDR_CTRL) |=> (o_rdata[7] == 1'b0))
		else $error("bit seven read as one");

	a_start_sets_go: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(state == st_idle && ctrl.enable && wr_ctrl && wctrl.go && wctrl.enable)
		|=> (ctrl.go && state == st_convert) ##1 ctrl.go)
		else $error("start did not set go");

	a_disabled_no_go: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(state == st_idle && !ctrl.enable) |=> !ctrl.go)
		else $error("go set while disabled");

	a_done_clears_go: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		complete |=> (!ctrl.go && status[adc0_pkg::STAT_DONE] && result == $past(next_sar)))
		else $error("completion effects missing");

	a_abort_fill: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(aborted && bit_idx != 4'(RES_BITS - 1)) |=> (!ctrl.go && result[0] == $past(abort_last)))
		else $error("abort fill wrong");

	a_trigger_timer: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		i_trigger |=> o_timer_clear)
		else $error("timer clear missing");

	a_disable_power: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(wr_ctrl && !wctrl.enable) |=> (!o_power_on && !ctrl.go))
		else $error("power stays on");

	a_route_input: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(ctrl.chan <= adc0_pkg::CHAN_LAST_INPUT) |-> (o_route.input_sel
		&& o_route.input_index == ctrl.chan[3:0] && !o_route.temp_sel))
		else $error("input route wrong");

	a_route_reserved: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(ctrl.chan > adc0_pkg::CHAN_LAST_INPUT && ctrl.chan < adc0_pkg::CHAN_TEMP)
		|-> (o_route == '0))
		else $error("reserved code routed");

	a_route_temp: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(ctrl.chan == adc0_pkg::CHAN_TEMP) |-> (o_route.temp_sel && !o_route.input_sel))
		else $error("temperature route wrong");

	a_route_reference: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(ctrl.chan == adc0_pkg::CHAN_FIXED_REFERENCE)
		|-> (o_route.fixed_reference_sel && !o_route.temp_sel))
		else $error("reference route wrong");

	a_abort_flags: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		aborted |=> (status[adc0_pkg::STAT_ABORT] && state == st_idle && !ctrl.go))
		else $error("abort did not stop conversion");

	a_busy_shows_go: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		ctrl.go == (state == st_convert))
		else $error("go differs from busy");

	a_off_no_go: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		!ctrl.enable |-> !ctrl.go)
		else $error("go set while off");

	a_power_follows: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		o_power_on == ctrl.enable)
		else $error("power differs from enable");

	c_complete: cover property (@(posedge i_mclk) disable iff (!i_resetn) complete);
	c_abort: cover property (@(posedge i_mclk) disable iff (!i_resetn) aborted);
	c_trigger_start: cover property (@(posedge i_mclk) disable iff (!i_resetn)
		(i_trigger && state == st_idle && ctrl.enable) ##1 ctrl.go);
	c_abort_midway: cover property (@(posedge i_mclk) disable iff (!i_resetn)
		aborted && bit_idx != 4'(RES_BITS - 1));
	c_disable_stop: cover property (@(posedge i_mclk) disable iff (!i_resetn)
		state == st_convert && wr_ctrl && !wctrl.enable);

endmodule

//--- tb/adc_analog_model.sv
`timescale 1ns/1ps
module adc_analog_model (
	input wire logic i_mclk,
	input wire logic i_power_on,
	input wire adc0_pkg::route_s i_route,
	input wire logic [9:0] i_dac_code,
	output logic o_cmp_above
);
	// ==========
	// Source in front of the comparator
	logic [9:0] level;
	logic toggle = 1'b0;
	always_comb begin
		level = 10'h000;
		if (i_route.input_sel) level = {i_route.input_index, 6'h15};
		if (i_route.temp_sel) level = 10'h2a5;
		if (i_route.fixed_reference_sel) level = 10'h155;
	end
	// Unpowered comparator output is garbage, never a stable answer
	always @(posedge i_mclk) toggle <= ~toggle;
	assign o_cmp_above = i_power_on ? (level >= i_dac_code) : toggle;
endmodule

//--- tb/adc_control_register_zero_tb.sv
`timescale 1ns/1ps
module adc_control_register_zero_tb;
	localparam logic [2:0] CTRL = adc0_pkg::ADDR_CTRL;
	localparam logic [2:0] STAT = adc0_pkg::ADDR_STAT;
	localparam logic [2:0] MASK = adc0_pkg::ADDR_MASK;
	localparam logic [2:0] RESH = adc0_pkg::ADDR_RESH;
	localparam logic [2:0] RESL = adc0_pkg::ADDR_RESL;
	logic i_mclk = 1'b0;
	logic i_resetn = 1'b0;
	logic [2:0] i_addr = 3'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_trigger = 1'b0;
	logic [7:0] o_rdata;
	logic o_timer_clear;
	logic cmp_above;
	logic [9:0] o_dac_code;
	logic o_power_on;
	adc0_pkg::route_s o_route;
	logic o_irq;
	int n_mismatch = 0;
	int n_compared = 0;
	int i;
	always #4 i_mclk = ~i_mclk;
	adc_control_zero dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_trigger(i_trigger), .o_timer_clear(o_timer_clear), .i_cmp_above(cmp_above),
		.o_dac_code(o_dac_code), .o_power_on(o_power_on), .o_route(o_route), .o_irq(o_irq));
	adc_analog_model model (.i_mclk(i_mclk), .i_power_on(o_power_on), .i_route(o_route),
		.i_dac_code(o_dac_code), .o_cmp_above(cmp_above));
	// ==========
	// Bus and check tasks
	task automatic conclude;
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	task automatic rdc(input logic [2:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(d, e);
	endtask
	task automatic conv(input logic [4:0] c, input logic [9:0] lvl, input logic irq);
		logic [7:0] d;
		int k;
		wr(CTRL, {1'b0, c, 2'b01});
		wr(CTRL, {1'b0, c, 2'b11});
		rdc(CTRL, {1'b0, c, 2'b11});
		d = 8'h02;
		for (k = 0; k < 40 && d[1]; k++) rd(CTRL, d);
		if (d[1]) begin
			n_mismatch++;
			conclude();
		end
		chk(d, {1'b0, c, 2'b01});
		chk(o_irq, irq);
		rdc(RESH, lvl[9:2]);
		rdc(RESL, {lvl[1:0], 6'h00});
		rdc(STAT, 8'h01);
		chk(o_irq, 1'b0);
	endtask
	task automatic trig;
		@(posedge i_mclk);
		i_trigger <= 1'b1;
		@(posedge i_mclk);
		i_trigger <= 1'b0;
		#1 chk(o_timer_clear, 1'b1);
		@(posedge i_mclk);
		#1 chk(o_timer_clear, 1'b0);
	endtask
	// ==========
	// Main sequence
	initial begin
		repeat (10) @(posedge i_mclk);
		i_resetn <= 1'b1;
		rdc(CTRL, 8'h00);
		rdc(STAT, 8'h00);
		rdc(3'h7, 8'h00);
		chk(o_power_on, 1'b0);
		wr(CTRL, 8'h82);
		rdc(CTRL, 8'h00);
		wr(CTRL, 8'h03);
		rdc(CTRL, 8'h01);
		chk(o_power_on, 1'b1);
		for (i = 0; i < 32; i++) begin
			wr(CTRL, {1'b0, i[4:0], 2'b01});
			rdc(CTRL, {1'b0, i[4:0], 2'b01});
			chk(o_route.input_sel, i < 12);
			chk(o_route.temp_sel, i == 29);
			chk(o_route.fixed_reference_sel, i == 30);
			if (i < 12) chk(o_route.input_index, i[3:0]);
		end
		rdc(STAT, 8'h00);
		wr(MASK, 8'h03);
		conv(5'h03, {4'h3, 6'h15}, 1'b1);
		conv(5'h1d, 10'h2a5, 1'b1);
		wr(MASK, 8'h00);
		conv(5'h1e, 10'h155, 1'b0);
		// Abort before any bit resolves: whole result takes the fill value
		wr(MASK, 8'h02);
		wr(CTRL, 8'h7b);
		wr(CTRL, 8'h79);
		rdc(RESH, 8'h00);
		rdc(RESL, 8'h00);
		chk(o_irq, 1'b1);
		rdc(STAT, 8'h02);
		// Abort with two bits resolved: the lower eight copy the last one
		wr(CTRL, 8'h7b);
		repeat (11) @(posedge i_mclk);
		wr(CTRL, 8'h79);
		rdc(RESH, 8'h7f);
		rdc(RESL, 8'hc0);
		chk(o_irq, 1'b1);
		rdc(STAT, 8'h02);
		trig();
		rdc(CTRL, 8'h7b);
		wr(CTRL, 8'h78);
		rdc(CTRL, 8'h78);
		chk(o_power_on, 1'b0);
		rdc(STAT, 8'h00);
		trig();
		rdc(CTRL, 8'h78);
		wr(CTRL, 8'h79);
		wr(CTRL, 8'h7b);
		@(posedge i_mclk);
		i_resetn <= 1'b0;
		@(posedge i_mclk);
		i_resetn <= 1'b1;
		rdc(CTRL, 8'h00);
		conclude();
	end
endmodule
